// [design/trsl_guard.v]
// trsl_guard.v: guard-time qualifier around the external rc network
// assumes: gt_lvl_i is already synchronised; ref_tick_i is a one-cycle
// pulse per reference clock period
`timescale 1ns/1ps
`default_nettype none

module trsl_guard (
  // clock, reset, enable
  input  wire       clk_sys_i,
  input  wire       rst_n_i,
  input  wire       ce_i,
  // qualifier inputs
  input  wire       ref_tick_i,
  input  wire       rx_en_i,
  input  wire       est_i,
  input  wire       gt_lvl_i,
  // pin drive and result
  output reg        pin_o,
  output reg        pin_oe_o,
  output reg        present_o,
  output reg        rise_o,
  output reg        fall_o
);

  // pin drive follows early steering; the rc network turns it into a
  // delayed level, and the returning level decides presence
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pin_o     <= 1'b0;
      pin_oe_o  <= 1'b0;
      present_o <= 1'b0;
      rise_o    <= 1'b0;
      fall_o    <= 1'b0;
    end else if (ce_i) begin
      rise_o   <= 1'b0;
      fall_o   <= 1'b0;
      // drive only while reception is allowed; released otherwise
      pin_oe_o <= rx_en_i;
      pin_o    <= rx_en_i & est_i;
      // evaluate only on reference ticks so timing follows the crystal
      if (ref_tick_i) begin
        if (!present_o && rx_en_i && gt_lvl_i) begin
          // charged past threshold: tone held for the present guard
          present_o <= 1'b1;
          rise_o    <= 1'b1;
        end else if (present_o && !gt_lvl_i) begin
          // discharged: absence held for the absent guard; a short
          // dropout never gets here because the cap stays charged
          present_o <= 1'b0;
          fall_o    <= 1'b1;
        end
      end
    end
  end

endmodule // trsl_guard

`default_nettype wire

// [design/trsl_regs.vh]
// trsl_regs.vh: offsets, fields and reset values of the tone receiver
// assumes: included by bare name from design files only
`ifndef TRSL_REGS_VH
`define TRSL_REGS_VH

// register byte offsets
`define TRSL_OFS_RXDATA  8'h00
`define TRSL_OFS_CTRL    8'h04
`define TRSL_OFS_STATUS  8'h08
`define TRSL_OFS_INTSTAT 8'h0c
`define TRSL_OFS_INTCLR  8'h10
`define TRSL_OFS_INTEN   8'h14

// control fields
`define TRSL_CTRL_MODE   1
`define TRSL_CTRL_IRQEN  2
`define TRSL_CTRL_EXTCK  3
`define TRSL_CTRL_RST    4'h0

// status fields
`define TRSL_ST_EARLY    0
`define TRSL_ST_GUARD    1
`define TRSL_ST_VALID    2
`define TRSL_ST_DSTEER   3

// interrupt status fields
`define TRSL_INT_NEWDATA 0
`define TRSL_INT_TONEEND 1
`define TRSL_INT_RST     2'h0

// data register reset value
`define TRSL_RX_RST      4'h0

`endif

// [design/trsl_top.v]
// trsl_top.v: receive qualification, data latch and status of the
// dual-tone receiver, with an apb register slave
// assumes: tone_detect_i and tone_code_i come from decoder logic on
// clk_sys_i; steer_guard_i and osc_in_pin_i are asynchronous pins
//
// Notes on behaviour
// - short tones never update data or flags
// - tone held for guard time gets latched
// - after absence guard, code held until next
// - dropouts shorter than absent guard ignored
// - received code is four bits wide
// - delayed steer reads low while signal valid
// - valid flag set on latch, status read clears
// - early steer follows raw frequency detection
// - guard pin drives rc, return level qualifies
// - timing derived from reference oscillator
// - external clock accepted, oscillator output idle
// - code uses transmitter digit encoding
// - call-progress mode blocks all reception
// - interrupt pin needs enable and tone mode
`timescale 1ns/1ps
`default_nettype none
`include "trsl_regs.vh"

module trsl_top (
  // clock, reset, enable
  input  wire        clk_sys_i,
  input  wire        rst_n_i,
  input  wire        ce_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  // tone decoder
  input  wire        tone_detect_i,
  input  wire [3:0]  tone_code_i,
  // guard pin
  input  wire        steer_guard_i,
  output reg         steer_guard_o,
  output reg         steer_guard_oe_o,
  // reference oscillator pins
  input  wire        osc_in_pin_i,
  output reg         osc_out_pin_o,
  output reg         osc_out_pin_oe_o,
  // status pins
  output reg         early_steer_out_o,
  output reg  [3:0]  rx_code_bits_o,
  output reg         irq_tone_out_n_o,
  output reg         irq_o
);

  // decode of a register offset, used by read and write paths
  function [2:0] reg_sel;
    input [7:0] a;
    begin
      case (a)
        `TRSL_OFS_RXDATA:  reg_sel = 3'h1;
        `TRSL_OFS_CTRL:    reg_sel = 3'h2;
        `TRSL_OFS_STATUS:  reg_sel = 3'h3;
        `TRSL_OFS_INTSTAT: reg_sel = 3'h4;
        `TRSL_OFS_INTCLR:  reg_sel = 3'h5;
        `TRSL_OFS_INTEN:   reg_sel = 3'h6;
        default:           reg_sel = 3'h0;
      endcase
    end
  endfunction

  // selector codes
  localparam [2:0] SEL_NONE = 3'h0;
  localparam [2:0] SEL_RX   = 3'h1;
  localparam [2:0] SEL_CTRL = 3'h2;
  localparam [2:0] SEL_STAT = 3'h3;
  localparam [2:0] SEL_IST  = 3'h4;
  localparam [2:0] SEL_ICLR = 3'h5;
  localparam [2:0] SEL_IEN  = 3'h6;

  // synchronisers for the two asynchronous pins
  reg        gt_s1_q;      // first stage, read only by second
  reg        gt_s2_q;      // guard pin level, safe to use
  reg        osc_s1_q;     // first stage, read only by second
  reg        osc_s2_q;     // reference level
  reg        osc_s3_q;     // previous reference level
  reg        ref_tick_q;   // one pulse per reference period

  // control and state registers
  reg [3:0]  ctrl_q;       // mode, irq enable, external clock
  reg [3:0]  rx_q;         // latched received code
  reg        valid_q;      // new data waiting for status read
  reg [1:0]  ist_q;        // sticky interrupt status
  reg [1:0]  ien_q;        // interrupt enables
  reg        est_q;        // early steering

  // guard qualifier results
  wire       g_pin;
  wire       g_pin_oe;
  wire       g_present;
  wire       g_rise;
  wire       g_fall;

  // bus decode
  wire [2:0] sel      = reg_sel(paddr_i);
  wire       acc      = psel_i & penable_i;
  wire       done     = acc & pready_o;
  wire       wr_done  = done & pwrite_i;
  wire       rd_stat  = done & ~pwrite_i & (sel == SEL_STAT);

  // reception allowed only in tone mode
  wire       cp_mode  = ctrl_q[`TRSL_CTRL_MODE];
  wire       rx_en    = ~cp_mode;
  wire       ext_clk  = ctrl_q[`TRSL_CTRL_EXTCK];

  // status word as read by software
  wire [3:0] status_w;
  assign status_w[`TRSL_ST_EARLY]  = est_q;
  assign status_w[`TRSL_ST_GUARD]  = gt_s2_q;
  assign status_w[`TRSL_ST_VALID]  = valid_q;
  // delayed steering is active low while a valid signal lasts
  assign status_w[`TRSL_ST_DSTEER] = ~g_present;

  // pin synchronisers; the reference edge detect reads stage two on
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      gt_s1_q    <= 1'b0;
      gt_s2_q    <= 1'b0;
      osc_s1_q   <= 1'b0;
      osc_s2_q   <= 1'b0;
      osc_s3_q   <= 1'b0;
      ref_tick_q <= 1'b0;
    end else if (ce_i) begin
      gt_s1_q    <= steer_guard_i;
      gt_s2_q    <= gt_s1_q;
      osc_s1_q   <= osc_in_pin_i;
      osc_s2_q   <= osc_s1_q;
      osc_s3_q   <= osc_s2_q;
      // the reference runs continuously, so every rising edge counts
      ref_tick_q <= osc_s2_q & ~osc_s3_q;
    end
  end

  // oscillator output: amplifier drive for a crystal, released when an
  // external buffered clock feeds the input instead
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      osc_out_pin_o    <= 1'b0;
      osc_out_pin_oe_o <= 1'b0;
    end else if (ce_i) begin
      osc_out_pin_o    <= ~osc_s2_q;
      osc_out_pin_oe_o <= ~ext_clk;
    end
  end

  // early steering follows raw detection in tone mode, with no guard qualification
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      est_q             <= 1'b0;
      early_steer_out_o <= 1'b0;
    end else if (ce_i) begin
      est_q             <= tone_detect_i & rx_en;
      early_steer_out_o <= tone_detect_i & rx_en;
    end
  end

  // guard-time qualifier on the rc pin
  trsl_guard u_guard (
    .clk_sys_i  (clk_sys_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .ref_tick_i (ref_tick_q),
    .rx_en_i    (rx_en),
    .est_i      (est_q),
    .gt_lvl_i   (gt_s2_q),
    .pin_o      (g_pin),
    .pin_oe_o   (g_pin_oe),
    .present_o  (g_present),
    .rise_o     (g_rise),
    .fall_o     (g_fall)
  );

  // pin outputs registered once more so they come straight from flops
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      steer_guard_o    <= 1'b0;
      steer_guard_oe_o <= 1'b0;
    end else if (ce_i) begin
      steer_guard_o    <= g_pin;
      steer_guard_oe_o <= g_pin_oe;
    end
  end

  // received code latch: only a qualified rise loads it, so short
  // bursts and dropouts leave it untouched
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rx_q           <= `TRSL_RX_RST;
      rx_code_bits_o <= `TRSL_RX_RST;
    end else if (ce_i) begin
      if (g_rise && rx_en) begin
        // decoder code is already in the transmit digit encoding
        rx_q           <= tone_code_i;
        rx_code_bits_o <= tone_code_i;
      end
      // otherwise held until the next valid pair
    end
  end

  // data-valid flag; a new latch in the read cycle wins over the clear
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      valid_q <= 1'b0;
    end else if (ce_i) begin
      if (g_rise && rx_en) begin
        valid_q <= 1'b1;
      end else if (rd_stat) begin
        valid_q <= 1'b0;
      end
    end
  end

  // interrupt pin: active low, needs enable and tone mode; it is set
  // with the valid flag, and a status read, call progress or disable releases it
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      irq_tone_out_n_o <= 1'b1;
    end else if (ce_i) begin
      if (g_rise && rx_en && ctrl_q[`TRSL_CTRL_IRQEN]) begin
        irq_tone_out_n_o <= 1'b0;
      end else if (rd_stat || cp_mode ||
                   !ctrl_q[`TRSL_CTRL_IRQEN]) begin
        irq_tone_out_n_o <= 1'b1;
      end
    end
  end

  // control register
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ctrl_q <= `TRSL_CTRL_RST;
    end else if (ce_i) begin
      if (wr_done && sel == SEL_CTRL) begin
        ctrl_q <= pwdata_i[3:0];
      end
    end
  end

  // sticky event bits and enables; a set in the clear cycle wins
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ist_q <= `TRSL_INT_RST;
      ien_q <= `TRSL_INT_RST;
    end else if (ce_i) begin
      if (wr_done && sel == SEL_IEN) begin
        ien_q <= pwdata_i[1:0];
      end
      ist_q <= (ist_q & ~((wr_done && sel == SEL_ICLR) ?
                          pwdata_i[1:0] : 2'h0))
             | {g_fall, g_rise & rx_en};
    end
  end

  // level interrupt from enabled sticky bits
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(ist_q & ien_q);
    end
  end

  // apb answer: one wait state, data and error captured with pready
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0;
    end else if (ce_i) begin
      pready_o  <= acc & ~pready_o;
      pslverr_o <= acc & ~pready_o & (sel == SEL_NONE);
      prdata_o  <= 32'h0;
      if (acc && !pready_o && !pwrite_i) begin
        case (sel)
          SEL_RX:   prdata_o <= {28'h0, rx_q};
          SEL_CTRL: prdata_o <= {28'h0, ctrl_q};
          SEL_STAT: prdata_o <= {28'h0, status_w};
          SEL_IST:  prdata_o <= {30'h0, ist_q};
          SEL_IEN:  prdata_o <= {30'h0, ien_q};
          // clear register is write-only and reads zero
          default:  prdata_o <= 32'h0;
        endcase
      end
    end
  end

endmodule // trsl_top

`default_nettype wire

// [tb/tb_tone_receiver_status_latch.sv]
// tb_tone_receiver_status_latch.sv: apb driven test of the receiver
// assumes: trsl_top, trsl_rc_model and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_tone_receiver_status_latch;
  logic clk_sys_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0;
  logic pwrite_i = 0, tone_detect_i = 0;
  logic [7:0]  paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, rd;
  logic [3:0]  tone_code_i = 0, rx;
  logic pready_o, pslverr_o, err, sg_i, sg_o, sg_oe, osc_i, osc_oe;
  logic early, irq_n, irq;
  int fails = 0, n_tests = 0, cyc = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  trsl_top i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .ce_i(1'b1), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .tone_detect_i(tone_detect_i), .tone_code_i(tone_code_i),
    .steer_guard_i(sg_i), .steer_guard_o(sg_o),
    .steer_guard_oe_o(sg_oe), .osc_in_pin_i(osc_i),
    .osc_out_pin_o(), .osc_out_pin_oe_o(osc_oe),
    .early_steer_out_o(early), .rx_code_bits_o(rx),
    .irq_tone_out_n_o(irq_n), .irq_o(irq));
  trsl_rc_model i_rc (.clk_i(clk_sys_i), .rst_n_i(rst_n_i),
    .drv_i(sg_o), .oe_i(sg_oe), .lvl_o(sg_i), .osc_o(osc_i));
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails++;
      end_sim;
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  // one apb transfer, held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    @(posedge clk_sys_i);
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task tone(input logic [3:0] c, input int n);
    tone_detect_i <= 1;
    tone_code_i <= c;
    wt(n);
    tone_detect_i <= 0;
  endtask
  initial begin
    wt(6);
    rst_n_i <= 1;
    wt(1);
    apb(0, 8'h04, 0); chk(rd, 0);
    apb(0, 8'h00, 0); chk(rd, 0);
    apb(0, 8'h18, 0); chk(err, 1);
    chk(rd, 0);
    chk(osc_oe, 1);
    chk(sg_oe, 1);
    apb(1, 8'h04, 32'h4);
    apb(1, 8'h14, 32'h1);
    tone(4'h5, 10); // burst shorter than guard time
    wt(100);
    chk(rx, 0);
    apb(0, 8'h0c, 0); chk(rd, 0);
    tone_detect_i <= 1;
    wt(120);
    chk(rx, 5);
    chk(irq_n, 0);
    chk(early, 1);
    apb(0, 8'h08, 0); chk(rd, 32'h7);
    apb(0, 8'h08, 0); chk(rd, 32'h3);
    chk(irq_n, 1);
    tone_detect_i <= 0; // short dropout with a new code
    wt(10);
    tone(4'h9, 100);
    chk(rx, 5);
    // tone just ended: early steer off, rc level and delayed steer held
    apb(0, 8'h08, 0); chk(rd, 32'h2);
    wt(150);
    chk(rx, 5);
    apb(0, 8'h08, 0); chk(rd, 32'h8);
    apb(0, 8'h0c, 0); chk(rd, 32'h3);
    chk(irq, 1);
    // the interrupt level follows the enable one cycle late
    apb(1, 8'h14, 0); wt(1);
    chk(irq, 0);
    apb(1, 8'h10, 32'h3);
    apb(0, 8'h0c, 0); chk(rd, 0);
    tone(4'hc, 150);
    chk(rx, 4'hc);
    apb(0, 8'h00, 0); chk(rd, 32'hc);
    apb(0, 8'h08, 0); chk(rd, 32'h6);
    apb(1, 8'h04, 32'he); // call progress, external reference
    wt(3);
    chk(osc_oe, 0);
    tone_detect_i <= 1;
    tone_code_i <= 4'h3;
    wt(150);
    chk(early, 0);
    chk(sg_oe, 0);
    chk(rx, 4'hc);
    chk(irq_n, 1);
    tone_detect_i <= 0;
    end_sim;
  end
endmodule // tb_tone_receiver_status_latch
`default_nettype wire

// [tb/trsl_rc_model.sv]
// trsl_rc_model.sv: rc network on the guard pin and reference clock
// assumes: clocked by the system clock of the bench
`timescale 1ns/1ps
`default_nettype none
module trsl_rc_model #(
  parameter int GUARD = 40, // guard time in cycles
  parameter int HALF  = 14  // half period of the reference
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // guard pin drive in, level and reference out
  input  wire logic drv_i,
  input  wire logic oe_i,
  output var logic  lvl_o,
  output var logic  osc_o
);
  int cnt; // rc charge time
  int oc;  // reference divider
  // reference runs free; level follows drive after guard time
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt <= 0;
      oc <= 0;
      lvl_o <= 1'b0;
      osc_o <= 1'b0;
    end else begin
      oc <= (oc == HALF - 1) ? 0 : oc + 1;
      if (oc == HALF - 1) osc_o <= ~osc_o;
      // a released pin discharges like a low drive
      if ((drv_i & oe_i) == lvl_o) cnt <= 0;
      else if (cnt == GUARD - 1) begin
        lvl_o <= ~lvl_o;
        cnt <= 0;
      end else cnt <= cnt + 1;
    end
  end
endmodule // trsl_rc_model
`default_nettype wire

// [tb/trsl_top_asserts.sv]
// trsl_top_asserts.sv: port-level checks of the tone receiver
// assumes: bound to trsl_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module trsl_top_asserts (
  // watched ports
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        tone_detect_i,
  input wire logic        steer_guard_i,
  input wire logic        steer_guard_o,
  input wire logic        steer_guard_oe_o,
  input wire logic        early_steer_out_o,
  input wire logic [3:0]  rx_code_bits_o,
  input wire logic        irq_tone_out_n_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // a read finishing in this cycle
  wire rd_done = psel_i & penable_i & pready_o & ~pwrite_i;
  AST_PREADY_PULSE: assert property (pready_o |=> !pready_o)
    else $error("pready held too long");
  AST_EARLY_OFF: assert property (!tone_detect_i |=> !early_steer_out_o)
    else $error("early steer without tone");
  // the pin drive trails early steering by two register stages
  AST_GUARD_DRV: assert property (!early_steer_out_o |-> ##2 !steer_guard_o)
    else $error("guard pin driven without early steer");
  // pin level passes two sync flops, the qualifier and the latch
  AST_CODE_QUAL: assert property ($changed(rx_code_bits_o) |-> $past(steer_guard_i, 4))
    else $error("code latched without qualified guard level");
  AST_IRQ_CLR: assert property (rd_done && paddr_i == 8'h08 |=> irq_tone_out_n_o || $changed(rx_code_bits_o))
    else $error("interrupt pin not cleared by status read");
  AST_IRQ_MODE: assert property ($fell(irq_tone_out_n_o) |-> steer_guard_oe_o)
    else $error("interrupt pin fell outside tone mode");
  AST_CP_BLOCK: assert property (!steer_guard_oe_o [*2] |-> !$past(early_steer_out_o))
    else $error("early steer in call progress mode");
  // read data is captured with pready from the cycle before, so compare with then
  AST_RX_READ: assert property (rd_done && paddr_i == 8'h00 |-> prdata_o == {28'h0, $past(rx_code_bits_o)})
    else $error("receive data read differs from code pins");
  cover property ($fell(irq_tone_out_n_o));
  cover property ($changed(rx_code_bits_o));
  cover property (!steer_guard_oe_o && tone_detect_i);
endmodule // trsl_top_asserts
bind trsl_top trsl_top_asserts i_chk (
  .clk_sys_i         (clk_sys_i),
  .rst_n_i           (rst_n_i),
  .psel_i            (psel_i),
  .penable_i         (penable_i),
  .pwrite_i          (pwrite_i),
  .paddr_i           (paddr_i),
  .prdata_o          (prdata_o),
  .pready_o          (pready_o),
  .tone_detect_i     (tone_detect_i),
  .steer_guard_i     (steer_guard_i),
  .steer_guard_o     (steer_guard_o),
  .steer_guard_oe_o  (steer_guard_oe_o),
  .early_steer_out_o (early_steer_out_o),
  .rx_code_bits_o    (rx_code_bits_o),
  .irq_tone_out_n_o  (irq_tone_out_n_o)
);
`default_nettype wire
